// >>> inc/eeprom_pkg.sv
`default_nettype none
package eeprom_pkg;
    // device address word
    localparam logic [3:0] DEV_TYPE = 4'hA;
    localparam int RW_BIT = 0;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // link timing
    localparam int LINK_CLK_NS = 80;
    localparam int WR_CYCLE_MS = 5;
    localparam int WR_CYCLE_CYC = WR_CYCLE_MS * 1000000 / LINK_CLK_NS;
    localparam int SYS_CLK_NS = 10;
    localparam int SCL_QTR_NS = 250;
    localparam int SCL_QTR_CYC = (SCL_QTR_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam logic [7:0] QTR_LAST = 8'(SCL_QTR_CYC - 1);
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_LAST = 2'h3;
    // controller registers
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam int CMD_START = 8;
    localparam int CMD_STOP = 9;
    localparam int CMD_READ = 10;
    localparam int CMD_NACK = 11;
    localparam int CMD_RECOVER = 12;
    localparam int ST_BUSY = 0;
    localparam int ST_NACK = 1;
    localparam int ST_RX_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [8:0] TX_IDLE = 9'h1FF;
endpackage
`default_nettype wire

// >>> inc/two_wire_if.sv
`default_nettype none
interface two_wire_if;
    logic scl;
    logic sda_ctl_o;
    logic sda_ctl_oe_n;
    logic sda_tgt_o;
    logic sda_tgt_oe_n;
    logic sda;
    // open drain, pulled up
    assign sda = !((!sda_ctl_oe_n && !sda_ctl_o) ||
                   (!sda_tgt_oe_n && !sda_tgt_o));
    modport controller (output scl, output sda_ctl_o, output sda_ctl_oe_n,
                        input sda);
    modport target (input scl, input sda, output sda_tgt_o,
                    output sda_tgt_oe_n);
endinterface
`default_nettype wire

// >>> verilog/sync2.sv
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // async in, synced out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/eeprom_target.sv
`default_nettype none
// Contract
// RULE_01: data changes only while clock low
// RULE_02: data falls, clock high: start event
// RULE_03: data rises, clock high: stop, end transfer
// RULE_04: stop after read returns to standby
// RULE_05: 8-bit words msb first, ack ninth clock
// RULE_06: standby after power-up, read stop, programming
// RULE_07: start, nine clocks, start, stop recovers
// RULE_08: device address word follows every start
// RULE_09: top four bits must be one-zero pattern
// RULE_10: next three bits match strap pins
// RULE_11: lsb one reads, zero writes
// RULE_12: match acks low, mismatch goes standby
// RULE_13: write inhibit high blocks programming
// RULE_14: write cycle at most 5 ms
// RULE_15: sample on clock rise, shift after fall
// RULE_16: write cycle ignores bus, no ack
// RULE_17: polling acked only after write finishes
// RULE_18: release data line unless sending low
module eeprom_target #(
    parameter int WR_CYCLE_CYC = eeprom_pkg::WR_CYCLE_CYC
) (
    // link clock, reset
    input wire logic link_clk,
    input wire logic reset,
    // two-wire bus
    two_wire_if.target bus,
    // strap pins
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic write_inhibit_pin,
    // memory core side
    input wire logic [7:0] rd_byte,
    output logic [7:0] wr_byte,
    output logic wr_strobe,
    output logic rd_taken,
    output logic selected,
    output logic read_mode,
    output logic prog_busy
);
    localparam int WR_CNT_W = $clog2(WR_CYCLE_CYC + 1);

    typedef enum logic [5:0] {
        T_STANDBY = 6'h01,
        T_ADDR = 6'h02,
        T_ACK = 6'h04,
        T_RX = 6'h08,
        T_TX = 6'h10,
        T_WRCYC = 6'h20
    } tgt_state_t;

    tgt_state_t state_r;
    logic [5:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [2:0] strap_s;
    logic wi_s;
    logic scl_p_r;
    logic sda_p_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic rw_r;
    logic got_r;
    logic sda_oe_n_r;
    logic sda_o_r;
    logic [WR_CNT_W-1:0] wr_cnt_r;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic wr_done;
    logic at_slot;

    function automatic logic addr_match(input logic [7:0] w,
                                        input logic [2:0] s);
        return w[7:4] == eeprom_pkg::DEV_TYPE && w[3:1] == s;
    endfunction

    ////////////////////////////////////////////////////////////////
    // pins into link clock

    sync2 #(.W(6)) u_sync (
        .clk(link_clk),
        .reset(reset),
        .d({bus.scl, bus.sda, addr_strap_bit2, addr_strap_bit1,
            addr_strap_bit0, write_inhibit_pin}),
        .q(pins_s)
    );

    assign scl_s = pins_s[5];
    assign sda_s = pins_s[4];
    assign strap_s = pins_s[3:1];
    assign wi_s = pins_s[0];

    always_ff @(posedge link_clk) begin
        if (reset) begin
            scl_p_r <= 1'b0;
            sda_p_r <= 1'b0;
        end else begin
            scl_p_r <= scl_s;
            sda_p_r <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_p_r;
    assign scl_fall = !scl_s && scl_p_r;
    // sda moving under high scl is framing
    assign start_ev = scl_s && scl_p_r && sda_p_r && !sda_s; // see RULE_01
    assign stop_ev = scl_s && scl_p_r && !sda_p_r && sda_s;
    assign at_slot = cnt_r == eeprom_pkg::ACK_SLOT;
    assign wr_done = wr_cnt_r == WR_CNT_W'(WR_CYCLE_CYC - 1);

    ////////////////////////////////////////////////////////////////
    // protocol state

    always_ff @(posedge link_clk) begin
        if (reset) begin
            state_r <= T_STANDBY; // see RULE_06
            cnt_r <= '0;
            sh_r <= '0;
            tx_r <= '0;
            rw_r <= 1'b0;
            got_r <= 1'b0;
        end else if (state_r == T_WRCYC) begin
            // deaf until programming ends
            if (wr_done) begin
                state_r <= T_STANDBY; // see RULE_16 RULE_17 RULE_06
            end
        end else if (start_ev) begin
            // any start outside the write cycle restarts address intake
            state_r <= T_ADDR; // see RULE_02 RULE_08 RULE_07
            cnt_r <= '0;
            got_r <= 1'b0;
        end else if (stop_ev) begin
            // stop after a full byte ends a write
            if (state_r == T_RX && got_r && !wi_s) begin
                state_r <= T_WRCYC; // see RULE_03 RULE_13
            end else begin
                state_r <= T_STANDBY; // see RULE_04 RULE_03
            end
        end else begin
            case (state_r)
                T_ADDR, T_RX: begin
                    if (scl_rise && !at_slot) begin
                        sh_r <= {sh_r[6:0], sda_s}; // see RULE_05 RULE_15
                        cnt_r <= cnt_r + 4'h1;
                    end else if (scl_fall && at_slot) begin
                        if (state_r == T_ADDR) begin
                            rw_r <= sh_r[eeprom_pkg::RW_BIT]; // see RULE_11
                        end else begin
                            got_r <= 1'b1;
                        end
                        if (state_r == T_RX || addr_match(sh_r, strap_s)) begin
                            state_r <= T_ACK; // see RULE_09 RULE_10
                        end else begin
                            state_r <= T_STANDBY; // see RULE_12
                        end
                    end
                end
                T_ACK: begin
                    if (scl_fall) begin
                        cnt_r <= '0;
                        tx_r <= rd_byte;
                        state_r <= rw_r ? T_TX : T_RX; // see RULE_11
                    end
                end
                T_TX: begin
                    if (scl_rise && at_slot) begin
                        cnt_r <= '0;
                        tx_r <= rd_byte;
                        if (sda_s) begin
                            state_r <= T_STANDBY;
                        end
                    end else if (scl_rise) begin
                        cnt_r <= cnt_r + 4'h1;
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // sda: only ever pulled low

    always_ff @(posedge link_clk) begin
        if (reset) begin
            sda_oe_n_r <= 1'b1;
            sda_o_r <= 1'b0;
        end else begin
            sda_o_r <= 1'b0; // see RULE_18
            if (state_r == T_WRCYC || start_ev || stop_ev) begin
                sda_oe_n_r <= 1'b1; // see RULE_16
            end else if (scl_fall) begin
                // only after a fall, never under high scl
                case (state_r)
                    T_ADDR: begin
                        sda_oe_n_r <= !(at_slot &&
                                        addr_match(sh_r, strap_s)); // see RULE_12
                    end
                    T_RX: begin
                        sda_oe_n_r <= !at_slot; // see RULE_05
                    end
                    T_ACK: begin
                        sda_oe_n_r <= rw_r ? rd_byte[7] : 1'b1; // see RULE_15
                    end
                    T_TX: begin
                        sda_oe_n_r <= at_slot ? 1'b1 : tx_r[7]; // see RULE_18
                    end
                    default: begin
                        sda_oe_n_r <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign bus.sda_tgt_oe_n = sda_oe_n_r;
    assign bus.sda_tgt_o = sda_o_r;

    ////////////////////////////////////////////////////////////////
    // self-timed write cycle

    always_ff @(posedge link_clk) begin
        if (reset || state_r != T_WRCYC) begin
            wr_cnt_r <= '0;
        end else begin
            wr_cnt_r <= wr_cnt_r + 1'b1; // see RULE_14
        end
    end

    ////////////////////////////////////////////////////////////////
    // memory core side

    always_ff @(posedge link_clk) begin
        if (reset) begin
            wr_byte <= '0;
            wr_strobe <= 1'b0;
            rd_taken <= 1'b0;
            selected <= 1'b0;
            read_mode <= 1'b0;
            prog_busy <= 1'b0;
        end else begin
            wr_strobe <= state_r == T_RX && scl_fall && at_slot &&
                         !start_ev && !stop_ev;
            if (state_r == T_RX && scl_fall && at_slot) begin
                wr_byte <= sh_r;
            end
            rd_taken <= state_r == T_TX && scl_rise && at_slot && !sda_s;
            selected <= state_r == T_ACK || state_r == T_RX ||
                        state_r == T_TX;
            read_mode <= rw_r;
            prog_busy <= state_r == T_WRCYC;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/bus_controller.sv
`default_nettype none
module bus_controller (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // two-wire bus
    two_wire_if.controller bus,
    // axi4-lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [3:0] {
        C_IDLE = 4'h1,
        C_START = 4'h2,
        C_BIT = 4'h4,
        C_STOP = 4'h8
    } ctl_state_t;

    ctl_state_t state_r;
    logic sda_s;
    logic aw_full_r;
    logic w_full_r;
    logic [3:0] awaddr_r;
    logic [31:0] cmd_r;
    logic [3:0] wstrb_r;
    logic [31:0] status;
    logic [7:0] qcnt_r;
    logic [1:0] ph_r;
    logic [3:0] bit_r;
    logic [8:0] tx_r;
    logic [8:0] rx_r;
    logic stop_r;
    logic rec_r;
    logic rec2_r;
    logic scl_r;
    logic sda_oe_n_r;
    logic sda_o_r;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        return a == r;
    endfunction

    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic ar_take = s_axi_arvalid && s_axi_arready;
    wire logic wr_do = aw_full_r && w_full_r && !s_axi_bvalid;
    // busy: answered but dropped
    wire logic go = wr_do && hit(awaddr_r, eeprom_pkg::REG_CMD) &&
                    wstrb_r[1:0] == 2'h3 && state_r == C_IDLE;
    wire logic tick = qcnt_r == eeprom_pkg::QTR_LAST;
    wire logic ph_end = tick && ph_r == eeprom_pkg::PH_LAST;

    sync2 #(.W(1)) u_sync (
        .clk(clk),
        .reset(reset),
        .d(bus.sda),
        .q(sda_s)
    );

    ////////////////////////////////////////////////////////////////
    // register slave

    always_ff @(posedge clk) begin
        if (reset) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            aw_full_r <= (aw_full_r || aw_take) && !wr_do;
            w_full_r <= (w_full_r || w_take) && !wr_do;
            s_axi_awready <= !((aw_full_r || aw_take) && !wr_do);
            s_axi_wready <= !((w_full_r || w_take) && !wr_do);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            awaddr_r <= '0;
            cmd_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                cmd_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= eeprom_pkg::RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= hit(awaddr_r, eeprom_pkg::REG_CMD) ?
                           eeprom_pkg::RESP_OKAY : eeprom_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        status = '0;
        status[eeprom_pkg::ST_BUSY] = state_r != C_IDLE;
        status[eeprom_pkg::ST_NACK] = rx_r[0];
        status[eeprom_pkg::ST_RX_LSB +: 8] = rx_r[8:1];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= eeprom_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= eeprom_pkg::RESP_OKAY;
                if (hit(s_axi_araddr, eeprom_pkg::REG_STATUS)) begin
                    s_axi_rdata <= status;
                end else if (hit(s_axi_araddr, eeprom_pkg::REG_CMD)) begin
                    s_axi_rdata <= cmd_r;
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= eeprom_pkg::RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // quarter divider

    always_ff @(posedge clk) begin
        if (reset || state_r == C_IDLE || tick) begin
            qcnt_r <= '0;
        end else begin
            qcnt_r <= qcnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || state_r == C_IDLE) begin
            ph_r <= '0;
        end else if (tick) begin
            ph_r <= ph_r + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // bit sequencer

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= C_IDLE;
            bit_r <= '0;
            tx_r <= eeprom_pkg::TX_IDLE;
            rx_r <= '0;
            stop_r <= 1'b0;
            rec_r <= 1'b0;
            rec2_r <= 1'b0;
        end else begin
            case (state_r)
                C_IDLE: begin
                    if (go) begin
                        stop_r <= cmd_r[eeprom_pkg::CMD_STOP] ||
                                  cmd_r[eeprom_pkg::CMD_RECOVER];
                        rec_r <= cmd_r[eeprom_pkg::CMD_RECOVER];
                        rec2_r <= 1'b0;
                        bit_r <= '0;
                        // released bits read the answer
                        if (cmd_r[eeprom_pkg::CMD_RECOVER]) begin
                            tx_r <= eeprom_pkg::TX_IDLE; // see RULE_07
                        end else if (cmd_r[eeprom_pkg::CMD_READ]) begin
                            tx_r <= {8'hFF, cmd_r[eeprom_pkg::CMD_NACK]};
                        end else begin
                            tx_r <= {cmd_r[7:0], 1'b1}; // see RULE_08
                        end
                        if (cmd_r[eeprom_pkg::CMD_START] ||
                            cmd_r[eeprom_pkg::CMD_RECOVER]) begin
                            state_r <= C_START; // see RULE_02
                        end else begin
                            state_r <= C_BIT;
                        end
                    end
                end
                C_START: begin
                    if (ph_end) begin
                        state_r <= rec2_r ? C_STOP : C_BIT; // see RULE_07
                    end
                end
                C_BIT: begin
                    if (tick && ph_r == eeprom_pkg::PH_SAMPLE) begin
                        rx_r <= {rx_r[7:0], sda_s};
                    end
                    if (ph_end) begin
                        tx_r <= {tx_r[7:0], 1'b1};
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == eeprom_pkg::ACK_SLOT) begin
                            bit_r <= '0;
                            if (rec_r && !rec2_r) begin
                                rec2_r <= 1'b1;
                                state_r <= C_START;
                            end else begin
                                state_r <= stop_r ? C_STOP : C_IDLE;
                            end
                        end
                    end
                end
                C_STOP: begin
                    if (ph_end) begin
                        state_r <= C_IDLE; // see RULE_03
                    end
                end
                default: begin
                    state_r <= C_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // pins: scl high in phases 1, 2; in stop, high in phases 1 to 3

    always_ff @(posedge clk) begin
        if (reset) begin
            scl_r <= 1'b1;
            sda_oe_n_r <= 1'b1;
            sda_o_r <= 1'b0;
        end else begin
            sda_o_r <= 1'b0;
            case (state_r)
                C_START: begin
                    scl_r <= ph_r == 2'h1 || ph_r == 2'h2;
                    sda_oe_n_r <= ph_r < 2'h2; // see RULE_02
                end
                C_BIT: begin
                    scl_r <= ph_r == 2'h1 || ph_r == 2'h2;
                    sda_oe_n_r <= tx_r[8]; // see RULE_01
                end
                C_STOP: begin
                    scl_r <= ph_r != 2'h0;
                    sda_oe_n_r <= ph_r >= 2'h2; // see RULE_03
                end
                default: begin
                end
            endcase
        end
    end

    assign bus.scl = scl_r;
    assign bus.sda_ctl_oe_n = sda_oe_n_r;
    assign bus.sda_ctl_o = sda_o_r;
endmodule
`default_nettype wire

// >>> testbench/serial_eeprom_bus_front_end_chk.sv
`default_nettype none
module serial_eeprom_bus_front_end_chk (
    // clocks and reset
    input wire logic clk,
    input wire logic link_clk,
    input wire logic reset,
    // two-wire bus
    input wire logic scl,
    input wire logic sda_tgt_o,
    input wire logic sda_tgt_oe_n,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    sequence start_ev;
        scl && $fell(sda);
    endsequence
    sequence stop_ev;
        scl && $rose(sda);
    endsequence
    a_tgt_od: assert property (@(posedge link_clk)
        disable iff (reset) !sda_tgt_o) else $error("sda driven high");
    a_tgt_scl_low: assert property (@(posedge link_clk)
        disable iff (reset) $changed(sda_tgt_oe_n) |-> !scl)
        else $error("sda moved, scl high");
    a_shift_fall: assert property (@(posedge link_clk)
        disable iff (reset) $fell(sda_tgt_oe_n) |-> !$past(scl))
        else $error("drive before scl fall");
    a_ack_hold: assert property (@(posedge link_clk)
        disable iff (reset) $fell(sda_tgt_oe_n) |=> !sda_tgt_oe_n [*8])
        else $error("low bit too short");
    a_start_quiet: assert property (@(posedge link_clk)
        disable iff (reset) start_ev |=> sda_tgt_oe_n [*8])
        else $error("drive after start");
    a_stop_quiet: assert property (@(posedge link_clk)
        disable iff (reset) stop_ev |=> sda_tgt_oe_n [*8])
        else $error("drive after stop");
    a_scl_high: assert property (@(posedge clk)
        disable iff (reset) $rose(scl) |=> scl [*8])
        else $error("scl high too short");
    a_scl_low: assert property (@(posedge clk)
        disable iff (reset) $fell(scl) |=> !scl [*8])
        else $error("scl low too short");
endmodule
`default_nettype wire

// >>> testbench/serial_eeprom_bus_front_end_tb.sv
`default_nettype none
module serial_eeprom_bus_front_end_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WR = 200;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset = 1'b1;
    logic inhibit = 1'b0;
    logic [2:0] strap = 3'h0;
    logic [7:0] rd_byte = 8'h00;
    logic [7:0] wr_byte;
    logic [8:0] e;
    logic wr_strobe, selected, read_mode, prog_busy;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, st, lfsr = 32'hCF79C509;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] q[$];
    int error_cnt = 0, compares = 0, busy_n = 0;
    two_wire_if bus ();
    eeprom_target #(.WR_CYCLE_CYC(WR)) eeprom_target_inst (
        .link_clk(link_clk), .reset(reset), .bus(bus),
        .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .write_inhibit_pin(inhibit),
        .rd_byte(rd_byte), .wr_byte(wr_byte), .wr_strobe(wr_strobe),
        .rd_taken(), .selected(selected), .read_mode(read_mode),
        .prog_busy(prog_busy));
    bus_controller bus_controller_inst (
        .clk(clk), .reset(reset), .bus(bus), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    serial_eeprom_bus_front_end_chk chk_inst (
        .clk(clk), .link_clk(link_clk), .reset(reset), .scl(bus.scl),
        .sda_tgt_o(bus.sda_tgt_o), .sda_tgt_oe_n(bus.sda_tgt_oe_n),
        .sda(bus.sda));
    ////////////////////////////////////////////////////////////////////////
    initial forever #5 clk = !clk;
    // offset: edges never meet clk
    initial begin
        #3;
        forever #40 link_clk = !link_clk;
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, x);
        compares++;
        if (s !== x) begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", n, x, s);
        end
    endtask
    task automatic summarize;
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tmo(input int i, input int n);
        if (i >= n) begin
            error_cnt++;
            summarize();
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        int i;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        tmo(i, 100);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        int i;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        tmo(i, 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // one sequence, poll until idle
    task automatic cmd(input logic [31:0] c);
        logic [1:0] r;
        int i;
        axw(4'h0, c, r);
        for (i = 0; i < 1000; i++) begin
            axr(4'h4, st, r);
            if (st[eeprom_pkg::ST_BUSY] === 1'b0) break;
        end
        tmo(i, 1000);
    endtask
    always @(posedge link_clk) begin
        if (prog_busy === 1'b1) busy_n++;
        if (wr_strobe === 1'b1) begin
            e = q.size() ? q.pop_front() : 9'h100;
            chk("wr_byte", wr_byte, e);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] a, b;
        logic [31:0] v;
        logic [1:0] r;
        int i;
        repeat (10) @(posedge link_clk);
        @(posedge clk);
        reset <= 1'b0;
        strap <= lfsr[2:0];
        a = {4'hA, lfsr[2:0], 1'b0};
        axw(4'h8, 32'h0, r);
        chk("bresp", r, eeprom_pkg::RESP_SLVERR);
        axr(4'h8, v, r);
        chk("rresp", r, eeprom_pkg::RESP_SLVERR);
        cmd(32'h100 | a);
        chk("ack_w", st[1], 0);
        chk("rmode", {selected, read_mode}, 2);
        lfsr = nx(lfsr);
        q.push_back(lfsr[7:0]);
        busy_n = 0;
        cmd(32'h200 | lfsr[7:0]);
        chk("ack_d", st[1], 0);
        for (i = 0; i < 20 && prog_busy !== 1'b1; i++) @(posedge link_clk);
        chk("busy", prog_busy, 1);
        cmd(32'h300 | a);
        chk("poll", st[1], 1);
        for (i = 0; i < 400 && prog_busy === 1'b1; i++) @(posedge link_clk);
        chk("wr_time", busy_n inside {[WR / 2:WR]}, 1);
        cmd(32'h300 | a);
        chk("poll_ok", st[1], 0);
        inhibit <= 1'b1;
        busy_n = 0;
        cmd(32'h100 | a);
        lfsr = nx(lfsr);
        q.push_back(lfsr[7:0]);
        cmd(32'h200 | lfsr[7:0]);
        inhibit <= 1'b0;
        for (i = 0; i < 20 && busy_n == 0; i++) @(posedge link_clk);
        chk("inhibit", busy_n, 0);
        lfsr = nx(lfsr);
        rd_byte <= lfsr[7:0];
        cmd(32'h101 | a);
        chk("rmode_r", {st[1], read_mode}, 1);
        cmd(32'hE00);
        chk("rx", st[15:8], lfsr[7:0]);
        for (i = 0; i < 20 && selected !== 1'b0; i++) @(posedge link_clk);
        chk("standby", selected, 0);
        for (i = 0; i < 6; i++) begin
            lfsr = nx(lfsr);
            b = {i[0] ? 4'hA : lfsr[7:4], i[1] ? a[3:1] : lfsr[3:1], 1'b0};
            cmd(32'h300 | b);
            chk("match", st[1], b[7:1] != a[7:1]);
        end
        // cut, then recover
        cmd(32'h100 | a);
        cmd(32'h1000);
        cmd(32'h300 | a);
        chk("recover", st[1], 0);
        summarize();
    end
endmodule
`default_nettype wire
